// File: core/rdw_walker.sv
// Receive descriptor walker: fetches descriptors, fills buffers, reports status.
// Assumes a host memory port that acknowledges each request with memAck.
//
// Overview of operation
// - End-of-ring flag sends the next fetch back to the list base.
// - Chained flag makes the fourth word the next descriptor address.
// - With both flags set, end-of-ring wins and returns to base.
// - Second size from bits 21:11; zero skips it to the next descriptor.
// - Second size is ignored whenever the chained flag is set.
// - First size from bits 10:0; zero skips to the second buffer.
// - Third word is the first buffer address, low two bits zero.
// - Fourth word is the second buffer address, low two bits zero.
// - Late collision or runt: dribble and CRC are not valid.
// - Runt under 14 bytes: frame type also not valid.
// - Overflow or watchdog: runt, collision, dribble and CRC also not valid.
// - Transmit descriptors offer two buffers with own sizes and pointers.
// - Completion status is meaningful only in the last descriptor.
`include "rdw_cfg.svh"

module rdw_walker
    import rdw_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStb,
    input  wire logic        regRdStb,
    output logic      [31:0] regRdData,
    output logic             irq,
    output logic             memRd,
    output logic             memWr,
    output logic      [31:0] memAddr,
    output logic      [31:0] memWrData,
    input  wire logic        memAck,
    input  wire logic [31:0] memRdData,
    input  wire logic        rxValid,
    input  wire logic [31:0] rxData,
    input  wire logic        rxLast,
    output logic             rxReady,
    input  wire logic        rxRunt,
    input  wire logic        rxCollision,
    input  wire logic        rxFrameType,
    input  wire logic        rxDribble,
    input  wire logic        rxCrcErr,
    input  wire logic        rxOverrun,
    input  wire logic        rxWatchdog,
    input  wire logic        rxShort,
    input  wire logic [1:0]  rxDataKind
);

    rdw_walk_s   s_q;
    rdw_walk_s   s_d;
    logic [1:0]  storeRdIdx;
    logic [31:0] storeRdData;
    logic        storeWrEn;

    rdw_desc_store u_store (
        .sys_clk (sys_clk),
        .srst    (srst),
        .wrEn    (storeWrEn),
        .wrIdx   (s_q.fetchIdx),
        .wrData  (memRdData),
        .rdIdx   (storeRdIdx),
        .rdData  (storeRdData)
    );

    always_comb begin
        logic        evFrame;
        logic        evDesc;
        logic        evFault;
        logic        ringWrap;
        logic        chained;
        logic [10:0] size1;
        logic [10:0] size2;
        logic        abnormal;
        logic        dribCrcBad;
        logic        runtCollBad;
        logic        ftypeBad;
        logic [7:0]  oc;
        logic [31:0] vw;
        logic [31:0] sw;
        logic [14:0] len;

        evFrame     = 1'b0;
        evDesc      = 1'b0;
        evFault     = 1'b0;
        ringWrap    = s_q.ctrlWord[`RDW_RING_WRAP_BIT];
        chained     = s_q.ctrlWord[`RDW_CHAINED_BIT];
        size1       = s_q.ctrlWord[`RDW_SIZE1_HI:`RDW_SIZE1_LO];
        size2       = chained ? 11'h000 : s_q.ctrlWord[`RDW_SIZE2_HI:`RDW_SIZE2_LO];
        oc          = s_q.outcome;
        abnormal    = oc[`RDW_IN_OVERRUN] | oc[`RDW_IN_WATCHDOG];
        runtCollBad = abnormal;
        dribCrcBad  = abnormal | oc[`RDW_IN_RUNT] | oc[`RDW_IN_COLL];
        ftypeBad    = oc[`RDW_IN_SHORT];
        len         = s_q.frameLen + `RDW_LEN_STEP;
        vw          = '0;
        sw          = '0;
        storeWrEn   = 1'b0;
        storeRdIdx  = `RDW_IDX_CTRL;
        s_d         = s_q;
        s_d.regRdData = '0;

        // Register port
        if (regRdStb) begin
            case (regAddr)
                `RDW_REG_CTRL:      s_d.regRdData = {31'h0, s_q.run};
                `RDW_REG_LIST_BASE: s_d.regRdData = s_q.listBase;
                `RDW_REG_CUR_DESC:  s_d.regRdData = s_q.curDesc;
                `RDW_REG_STATUS:    s_d.regRdData = s_q.statusWord;
                `RDW_REG_VALID:     s_d.regRdData = s_q.validWord;
                `RDW_REG_INT_STAT:  s_d.regRdData = {29'h0, s_q.intStat};
                `RDW_REG_INT_EN:    s_d.regRdData = {29'h0, s_q.intEn};
                default:            s_d.regRdData = '0;
            endcase
        end

        if (regWrStb) begin
            case (regAddr)
                `RDW_REG_CTRL:      s_d.run = regWrData[`RDW_CTRL_RUN];
                `RDW_REG_LIST_BASE: s_d.listBase = regWrData;
                `RDW_REG_INT_EN:    s_d.intEn = regWrData[2:0];
                `RDW_REG_INT_CLR:   s_d.intStat = s_q.intStat & ~regWrData[2:0];
                default:            ;
            endcase
        end

        // Walker
        case (s_q.state)
            ST_IDLE: begin
                if (s_q.run) begin
                    s_d.curDesc  = s_q.listBase;
                    s_d.fetchIdx = `RDW_IDX_CTRL;
                    s_d.memAddr  = s_q.listBase + `RDW_WORD_BYTES;
                    s_d.memRd    = 1'b1;
                    s_d.state    = ST_FETCH;
                end
            end

            ST_FETCH: begin
                if (memAck) begin
                    storeWrEn = 1'b1;
                    if (s_q.fetchIdx == `RDW_IDX_ADDR2) begin
                        s_d.memRd = 1'b0;
                        s_d.state = ST_LOADC;
                    end else begin
                        s_d.fetchIdx = s_q.fetchIdx + 2'h1;
                        s_d.memAddr  = s_q.memAddr + `RDW_WORD_BYTES;
                    end
                end
            end

            ST_LOADC: begin
                s_d.ctrlWord = storeRdData;
                storeRdIdx   = `RDW_IDX_ADDR1;
                s_d.state    = ST_LOADA1;
            end

            ST_LOADA1: begin
                s_d.addr1  = storeRdData;
                storeRdIdx = `RDW_IDX_ADDR2;
                s_d.state  = ST_LOADA2;
            end

            ST_LOADA2: begin
                s_d.addr2 = storeRdData;
                s_d.size2 = size2;
                if (ringWrap) begin
                    s_d.nextDesc = s_q.listBase;
                end else if (chained) begin
                    s_d.nextDesc = storeRdData;
                end else begin
                    s_d.nextDesc = s_q.curDesc + `RDW_DESC_STRIDE;
                end

                if (size1 != 11'h000) begin
                    s_d.bufPtr  = s_q.addr1;
                    s_d.remain  = size1;
                    s_d.bufSel  = 1'b0;
                    s_d.rxReady = 1'b1;
                    s_d.state   = ST_BUF;
                end else if (size2 != 11'h000) begin
                    s_d.bufPtr  = storeRdData;
                    s_d.remain  = size2;
                    s_d.bufSel  = 1'b1;
                    s_d.rxReady = 1'b1;
                    s_d.state   = ST_BUF;
                end else begin
                    evFault       = s_q.inFrame;
                    evDesc        = 1'b1;
                    s_d.descFault = s_q.descFault | s_q.inFrame;
                    s_d.state     = ST_NEXT;
                end
            end

            ST_BUF: begin
                if (rxValid && s_q.rxReady) begin
                    s_d.rxReady   = 1'b0;
                    s_d.memWr     = 1'b1;
                    s_d.memAddr   = s_q.bufPtr;
                    s_d.memWrData = rxData;
                    s_d.lastBeat  = rxLast;
                    s_d.outcome[`RDW_IN_RUNT]     = rxRunt;
                    s_d.outcome[`RDW_IN_COLL]     = rxCollision;
                    s_d.outcome[`RDW_IN_FTYPE]    = rxFrameType;
                    s_d.outcome[`RDW_IN_DRIBBLE]  = rxDribble;
                    s_d.outcome[`RDW_IN_CRC]      = rxCrcErr;
                    s_d.outcome[`RDW_IN_OVERRUN]  = rxOverrun;
                    s_d.outcome[`RDW_IN_WATCHDOG] = rxWatchdog;
                    s_d.outcome[`RDW_IN_SHORT]    = rxShort;
                    s_d.dataKind  = rxDataKind;

                    if (!s_q.inFrame) begin
                        s_d.inFrame   = 1'b1;
                        s_d.startHere = 1'b1;
                        s_d.frameLen  = '0;
                    end
                    s_d.state = ST_WRWAIT;
                end else if (!s_q.run && !s_q.inFrame) begin
                    // Stopped between frames: refuse further beats
                    s_d.rxReady = 1'b0;
                    s_d.state   = ST_IDLE;
                end
            end

            ST_WRWAIT: begin
                if (memAck) begin
                    s_d.memWr    = 1'b0;
                    s_d.frameLen = len;

                    if (s_q.lastBeat) begin
                        // Status only in the descriptor closing the frame
                        vw[`RDW_ST_RUNT]    = ~runtCollBad;
                        vw[`RDW_ST_COLL]    = ~runtCollBad;
                        vw[`RDW_ST_DRIBBLE] = ~dribCrcBad;
                        vw[`RDW_ST_CRC]     = ~dribCrcBad;
                        vw[`RDW_ST_FTYPE]   = ~ftypeBad;

                        sw[`RDW_ST_RUNT]     = oc[`RDW_IN_RUNT] & vw[`RDW_ST_RUNT];
                        sw[`RDW_ST_COLL]     = oc[`RDW_IN_COLL] & vw[`RDW_ST_COLL];
                        sw[`RDW_ST_DRIBBLE]  = oc[`RDW_IN_DRIBBLE] & vw[`RDW_ST_DRIBBLE];
                        sw[`RDW_ST_CRC]      = oc[`RDW_IN_CRC] & vw[`RDW_ST_CRC];
                        sw[`RDW_ST_FTYPE]    = oc[`RDW_IN_FTYPE] & vw[`RDW_ST_FTYPE];
                        sw[`RDW_ST_OVERRUN]  = oc[`RDW_IN_OVERRUN];
                        sw[`RDW_ST_WATCHDOG] = oc[`RDW_IN_WATCHDOG];
                        sw[`RDW_ST_LAST]     = 1'b1;
                        sw[`RDW_ST_FIRST]    = s_q.startHere;
                        sw[`RDW_ST_KIND_LO+1:`RDW_ST_KIND_LO] = s_q.dataKind;
                        sw[`RDW_ST_FAULT]    = s_q.descFault;
                        sw[`RDW_ST_SUMMARY]  = sw[`RDW_ST_RUNT] | sw[`RDW_ST_COLL]
                                             | sw[`RDW_ST_CRC] | abnormal | s_q.descFault;
                        sw[`RDW_ST_LEN_LO+14:`RDW_ST_LEN_LO] = len;

                        vw[`RDW_ST_OVERRUN]  = 1'b1;
                        vw[`RDW_ST_WATCHDOG] = 1'b1;
                        vw[`RDW_ST_LAST]     = 1'b1;
                        vw[`RDW_ST_FIRST]    = 1'b1;
                        vw[`RDW_ST_KIND_LO+1:`RDW_ST_KIND_LO] = 2'h3;
                        vw[`RDW_ST_FAULT]    = 1'b1;
                        vw[`RDW_ST_SUMMARY]  = 1'b1;
                        vw[`RDW_ST_LEN_LO+14:`RDW_ST_LEN_LO] = 15'h7fff;

                        s_d.statusWord = sw;
                        s_d.validWord  = vw;
                        s_d.inFrame    = 1'b0;
                        s_d.descFault  = 1'b0;
                        evFrame        = 1'b1;
                        evDesc         = 1'b1;
                        s_d.state      = ST_NEXT;
                    end else if (s_q.remain <= `RDW_SIZE_STEP) begin
                        if (!s_q.bufSel && (s_q.size2 != 11'h000)) begin
                            s_d.bufPtr  = s_q.addr2;
                            s_d.remain  = s_q.size2;
                            s_d.bufSel  = 1'b1;
                            s_d.rxReady = 1'b1;
                            s_d.state   = ST_BUF;
                        end else begin
                            evDesc    = 1'b1;
                            s_d.state = ST_NEXT;
                        end
                    end else begin
                        s_d.bufPtr  = s_q.bufPtr + `RDW_WORD_BYTES;
                        s_d.remain  = s_q.remain - `RDW_SIZE_STEP;
                        s_d.rxReady = 1'b1;
                        s_d.state   = ST_BUF;
                    end
                end
            end

            ST_NEXT: begin
                s_d.curDesc   = s_q.nextDesc;
                s_d.startHere = 1'b0;
                if (s_q.run) begin
                    s_d.fetchIdx = `RDW_IDX_CTRL;
                    s_d.memAddr  = s_q.nextDesc + `RDW_WORD_BYTES;
                    s_d.memRd    = 1'b1;
                    s_d.state    = ST_FETCH;
                end else begin
                    s_d.state = ST_IDLE;
                end
            end

            default: begin
                s_d.state = ST_IDLE;
            end
        endcase

        // Events win over a clear in the same cycle
        s_d.intStat[`RDW_INT_FRAME] = s_d.intStat[`RDW_INT_FRAME] | evFrame;
        s_d.intStat[`RDW_INT_DESC]  = s_d.intStat[`RDW_INT_DESC] | evDesc;
        s_d.intStat[`RDW_INT_FAULT] = s_d.intStat[`RDW_INT_FAULT] | evFault;
        s_d.irq = |(s_q.intStat & s_q.intEn);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_q       <= '0;
            s_q.state <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign regRdData = s_q.regRdData;
    assign irq       = s_q.irq;
    assign memRd     = s_q.memRd;
    assign memWr     = s_q.memWr;
    assign memAddr   = s_q.memAddr;
    assign memWrData = s_q.memWrData;
    assign rxReady   = s_q.rxReady;

endmodule // rdw_walker

// File: core/rdw_cfg.svh
// Offsets, field positions and strides for the receive walker.
// Assumes byte addressing of host memory and a byte-addressed register port.
`ifndef RDW_CFG_SVH
`define RDW_CFG_SVH

// Register offsets
`define RDW_REG_CTRL      8'h00
`define RDW_REG_LIST_BASE 8'h04
`define RDW_REG_CUR_DESC  8'h08
`define RDW_REG_STATUS    8'h0c
`define RDW_REG_VALID     8'h10
`define RDW_REG_INT_STAT  8'h14
`define RDW_REG_INT_EN    8'h18
`define RDW_REG_INT_CLR   8'h1c

// Control register
`define RDW_CTRL_RUN      0

// Descriptor control word fields
`define RDW_RING_WRAP_BIT 25
`define RDW_CHAINED_BIT   24
`define RDW_SIZE2_HI      21
`define RDW_SIZE2_LO      11
`define RDW_SIZE1_HI      10
`define RDW_SIZE1_LO      0

// Descriptor geometry in bytes
`define RDW_DESC_STRIDE   32'h0000_0010
`define RDW_WORD_BYTES    32'h0000_0004
`define RDW_SIZE_STEP     11'h004
`define RDW_LEN_STEP      15'h0004

// Fetched word indices
`define RDW_IDX_CTRL      2'h1
`define RDW_IDX_ADDR1     2'h2
`define RDW_IDX_ADDR2     2'h3

// Completion status word fields
`define RDW_ST_OVERRUN    0
`define RDW_ST_CRC        1
`define RDW_ST_DRIBBLE    2
`define RDW_ST_WATCHDOG   4
`define RDW_ST_FTYPE      5
`define RDW_ST_COLL       6
`define RDW_ST_LAST       8
`define RDW_ST_FIRST      9
`define RDW_ST_RUNT       11
`define RDW_ST_KIND_LO    12
`define RDW_ST_FAULT      14
`define RDW_ST_SUMMARY    15
`define RDW_ST_LEN_LO     16

// Latched receive outcome vector
`define RDW_IN_RUNT       0
`define RDW_IN_COLL       1
`define RDW_IN_FTYPE      2
`define RDW_IN_DRIBBLE    3
`define RDW_IN_CRC        4
`define RDW_IN_OVERRUN    5
`define RDW_IN_WATCHDOG   6
`define RDW_IN_SHORT      7

// Interrupt status bits
`define RDW_INT_FRAME     0
`define RDW_INT_DESC      1
`define RDW_INT_FAULT     2

`endif

// File: core/rdw_pkg.sv
// Types shared by the receive descriptor walker and its descriptor store.
// Assumes rdw_cfg.svh supplies all numeric constants.
package rdw_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_LOADC,
        ST_LOADA1,
        ST_LOADA2,
        ST_BUF,
        ST_WRWAIT,
        ST_NEXT
    } rdw_state_e;

    // Transmit descriptor offers two buffers, each with size and pointer
    typedef struct packed {
        logic [10:0] secondBufferSize;
        logic [10:0] firstBufferSize;
        logic [31:0] bufAddr1;
        logic [31:0] bufAddr2;
    } rdw_tx_desc_s;

    typedef struct packed {
        logic [3:0][31:0] words;
        logic [31:0]      rdData;
    } rdw_store_s;

    typedef struct packed {
        rdw_state_e  state;
        logic        run;
        logic [31:0] listBase;
        logic [31:0] curDesc;
        logic [31:0] nextDesc;
        logic [1:0]  fetchIdx;
        logic [31:0] ctrlWord;
        logic [31:0] addr1;
        logic [31:0] addr2;
        logic [10:0] size2;
        logic [31:0] bufPtr;
        logic [10:0] remain;
        logic        bufSel;
        logic        inFrame;
        logic        startHere;
        logic        descFault;
        logic        lastBeat;
        logic [7:0]  outcome;
        logic [1:0]  dataKind;
        logic [14:0] frameLen;
        logic [31:0] statusWord;
        logic [31:0] validWord;
        logic [2:0]  intStat;
        logic [2:0]  intEn;
        logic        irq;
        logic [31:0] regRdData;
        logic        memRd;
        logic        memWr;
        logic [31:0] memAddr;
        logic [31:0] memWrData;
        logic        rxReady;
    } rdw_walk_s;

endpackage

// File: core/rdw_desc_store.sv
// Four-word store for one fetched receive descriptor.
// Assumes one writer and one reader in the same clock domain.
`include "rdw_cfg.svh"

module rdw_desc_store
    import rdw_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        wrEn,
    input  wire logic [1:0]  wrIdx,
    input  wire logic [31:0] wrData,
    input  wire logic [1:0]  rdIdx,
    output logic      [31:0] rdData
);

    rdw_store_s s_q;
    rdw_store_s s_d;

    always_comb begin
        s_d = s_q;
        if (wrEn) begin
            s_d.words[wrIdx] = wrData;
        end
        s_d.rdData = s_q.words[rdIdx];
        if (wrEn && (wrIdx == rdIdx)) begin
            s_d.rdData = wrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.rdData;

endmodule // rdw_desc_store

// File: verification/rdw_walker_assertions.sv
// Port checker for the receive descriptor walker.
// Assumes one clock and a synchronous active-high reset.
module rdw_walker_assertions (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        memRd,
    input wire logic        memWr,
    input wire logic [31:0] memAddr,
    input wire logic [31:0] memWrData,
    input wire logic        memAck,
    input wire logic        rxValid,
    input wire logic        rxReady,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    logic [1:0] fetchCnt_q;

    // Acks seen within one descriptor fetch
    always_ff @(posedge sys_clk) begin
        if (srst || !memRd) begin
            fetchCnt_q <= 2'h0;
        end else if (memAck) begin
            fetchCnt_q <= fetchCnt_q + 2'h1;
        end
    end

    a_wr_aligned: assert property (memWr |-> memAddr[1:0] == 2'b00)
        else $error("buffer write not longword aligned");
    a_wr_hold: assert property (memWr && !memAck |=> memWr && $stable(memAddr) && $stable(memWrData))
        else $error("buffer write changed before ack");
    a_wr_release: assert property (memWr && memAck |=> !memWr)
        else $error("buffer write held after ack");
    a_rd_hold: assert property (memRd && !memAck |=> memRd && $stable(memAddr))
        else $error("descriptor read changed before ack");
    a_fetch_step: assert property (memRd && memAck && fetchCnt_q != 2'h2 |=> memRd && memAddr == $past(memAddr) + 32'h4)
        else $error("descriptor fetch did not step by one word");
    a_fetch_end: assert property (memRd && memAck && fetchCnt_q == 2'h2 |=> !memRd)
        else $error("descriptor fetch longer than three words");
    a_beat_taken: assert property (rxValid && rxReady |=> !rxReady && memWr)
        else $error("accepted beat not written");
    a_busy_refuse: assert property ((memRd || memWr) |-> !rxReady)
        else $error("ready while memory busy");

    c_beat: cover property (rxValid && rxReady);
    c_fetch: cover property (memRd && memAck && fetchCnt_q == 2'h2);
    c_irq: cover property ($rose(irq));
endmodule // rdw_walker_assertions

// File: verification/rdw_host_model.sv
// Host memory model answering descriptor reads and buffer writes.
// Assumes requests hold until acked; lag sets extra wait cycles.
module rdw_host_model (
    input  wire logic        sys_clk,
    input  wire logic        memRd,
    input  wire logic        memWr,
    input  wire logic [31:0] memAddr,
    input  wire logic [31:0] memWrData,
    input  wire logic [3:0]  lag,
    output logic             memAck,
    output logic      [31:0] memRdData
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] mem [1024];
    logic [3:0]  cnt;

    initial begin
        memAck = 1'b0;
        memRdData = 32'h0;
        cnt = 4'h0;
        for (int i = 0; i < 1024; i++) mem[i] = 32'hffff_ffff;
    end

    // One ack per request, data changes every idle cycle
    always @(posedge sys_clk) begin
        memAck <= 1'b0;
        memRdData <= ~memRdData;
        if ((memRd || memWr) && !memAck) begin
            if (cnt >= lag) begin
                memAck <= 1'b1;
                cnt <= 4'h0;
                if (memRd) memRdData <= mem[memAddr[11:2]];
                else mem[memAddr[11:2]] <= memWrData;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // rdw_host_model

// File: verification/tb_rx_descriptor_buffer_walker.sv
// Testbench for the receive descriptor walker.
// Assumes rdw_host_model as host memory and a 10 MHz clock.
`include "rdw_cfg.svh"

module tb_rx_descriptor_buffer_walker;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk = 1'b0, srst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWrData = 32'h0, rxData = 32'h0, regRdData, memAddr, memWrData, memRdData;
    logic irq, memRd, memWr, memAck, rxReady, rxValid = 1'b0, rxLast = 1'b0;
    logic rxRunt = 1'b0, rxCollision = 1'b0, rxFrameType = 1'b0, rxDribble = 1'b0;
    logic rxCrcErr = 1'b0, rxOverrun = 1'b0, rxWatchdog = 1'b0, rxShort = 1'b0;
    logic [1:0] rxDataKind = 2'h2;
    logic [3:0] lag = 4'h0;
    int miscompares = 0;
    int cmp_count = 0;

    always #50 sys_clk = ~sys_clk;

    rdw_walker dut (.sys_clk, .srst, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
        .irq, .memRd, .memWr, .memAddr, .memWrData, .memAck, .memRdData, .rxValid, .rxData,
        .rxLast, .rxReady, .rxRunt, .rxCollision, .rxFrameType, .rxDribble, .rxCrcErr,
        .rxOverrun, .rxWatchdog, .rxShort, .rxDataKind);
    rdw_host_model host (.sys_clk, .memRd, .memWr, .memAddr, .memWrData, .lag, .memAck, .memRdData);

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a; regWrData <= d; regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge sys_clk);
        regAddr <= a; regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 q = regRdData;
    endtask

    // Offer one beat and hold it until taken
    task automatic beat(input logic [31:0] d, input logic l, input logic [7:0] f);
        int n = 0;
        @(posedge sys_clk);
        rxValid <= 1'b1; rxData <= d; rxLast <= l;
        {rxShort, rxWatchdog, rxOverrun, rxCrcErr, rxDribble, rxFrameType, rxCollision, rxRunt} <= f;
        #1;
        while (rxReady !== 1'b1) begin
            if (n++ > 500) begin chk(32'h0, 32'h1); complete_run; end
            @(posedge sys_clk); #1;
        end
        @(posedge sys_clk);
        rxValid <= 1'b0;
    endtask

    task automatic settle;
        int n = 0;
        do begin @(posedge sys_clk); #1; n++; end while (memWr !== 1'b0 && n < 100);
        if (n >= 100) begin chk(32'h0, 32'h1); complete_run; end
    endtask

    task automatic setd(input logic [31:0] a, input logic [31:0] c, b1, b2);
        host.mem[a[11:2] + 10'h1] = c;
        host.mem[a[11:2] + 10'h2] = b1;
        host.mem[a[11:2] + 10'h3] = b2;
    endtask

    task automatic walk_test;
        logic [31:0] ea [10] = '{32'h400, 32'h404, 32'h500, 32'h600, 32'h700, 32'h780, 32'h800,
            32'h504, 32'h580, 32'h680};
        logic [31:0] ed [10] = '{32'hd000_0007, 32'hd000_0001, 32'hd000_0002, 32'hd000_0003,
            32'hd000_0004, 32'hd000_0005, 32'hd000_0006, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
        logic [31:0] q;
        setd(32'h100, 32'h0000_2008, 32'h400, 32'h500);
        setd(32'h110, 32'h0000_0004, 32'h600, 32'h580);
        setd(32'h120, 32'h0000_2000, 32'h680, 32'h700);
        setd(32'h130, 32'h013f_e004, 32'h780, 32'h160);
        setd(32'h160, 32'h0300_0004, 32'h800, 32'h200);
        wr(`RDW_REG_LIST_BASE, 32'h100);
        wr(`RDW_REG_CTRL, 32'h1);
        for (int i = 0; i < 8; i++) beat(32'hd000_0000 + i, i == 4 || i == 7, 8'h00);
        settle;
        for (int i = 0; i < 10; i++) chk(host.mem[ea[i][11:2]], ed[i]);
        rd(`RDW_REG_STATUS, q);
        chk(q, 32'h000c_2100);
    endtask

    task automatic status_test;
        logic [7:0] fl [6] = '{8'h1c, 8'h3c, 8'h5c, 8'h1e, 8'h1d, 8'h9d};
        logic [31:0] ev [6] = '{32'h8967, 32'h8121, 32'h8121, 32'h8961, 32'h8961, 32'h8941};
        logic [31:0] es [6] = '{32'h0004_a326, 32'h0004_a321, 32'h0004_a330,
            32'h0004_a360, 32'h0004_ab20, 32'h0004_ab00};
        logic [31:0] q;
        lag <= 4'h3;
        for (int i = 0; i < 6; i++) begin
            beat(32'he000_0000 + i, 1'b1, fl[i]);
            settle;
            rd(`RDW_REG_VALID, q);
            chk(q, ev[i] | 32'h7fff_7210);
            rd(`RDW_REG_STATUS, q);
            chk(q, es[i]);
        end
    endtask

    // Frame crosses a descriptor with no buffers, then wraps to base
    task automatic fault_test;
        logic [31:0] q;
        setd(32'h130, 32'h0200_0000, 32'h780, 32'h160);
        beat(32'hf000_0000, 1'b0, 8'h00);
        beat(32'hf000_0001, 1'b1, 8'h00);
        settle;
        chk(host.mem[10'h1c0], 32'hf000_0000);
        chk(host.mem[10'h100], 32'hf000_0001);
        rd(`RDW_REG_STATUS, q);
        chk(q, 32'h0008_e100);
    endtask

    task automatic irq_test;
        logic [31:0] q;
        rd(`RDW_REG_INT_STAT, q);
        chk(q, 32'h7);
        wr(`RDW_REG_INT_EN, 32'h1);
        @(posedge sys_clk); #1 chk({31'h0, irq}, 32'h1);
        wr(`RDW_REG_INT_EN, 32'h0);
        @(posedge sys_clk); #1 chk({31'h0, irq}, 32'h0);
        wr(`RDW_REG_INT_EN, 32'h1);
        wr(`RDW_REG_INT_CLR, 32'h7);
        @(posedge sys_clk); #1 chk({31'h0, irq}, 32'h0);
        rd(`RDW_REG_INT_STAT, q);
        chk(q, 32'h0);
        rd(8'h20, q);
        chk(q, 32'h0);
        wr(`RDW_REG_CTRL, 32'h0);
        @(posedge sys_clk); #1 chk({31'h0, rxReady}, 32'h0);
    endtask

    initial begin
        logic [31:0] q;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        rd(`RDW_REG_INT_STAT, q);
        chk(q, 32'h0);
        walk_test;
        status_test;
        fault_test;
        irq_test;
        complete_run;
    end
endmodule // tb_rx_descriptor_buffer_walker

bind rdw_walker rdw_walker_assertions chk_i (.sys_clk, .srst, .memRd, .memWr, .memAddr, .memWrData,
    .memAck, .rxValid, .rxReady, .irq);
